//--- bus_host_model.sv
// two-wire bus host model, open drain, phase length set by q
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_low_o
);
    // quarter bit in core clocks; raise it to play a slow host
    int q = 5;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start();
        w(q);
        sda_low_o = 1'b0;
        w(q);
        scl_o = 1'b1;
        w(q);
        sda_low_o = 1'b1;
        w(q);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        w(q);
        sda_low_o = 1'b1;
        w(q);
        scl_o = 1'b1;
        w(q);
        sda_low_o = 1'b0;
        w(q);
    endtask
    // sda moves only mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        w(q);
        sda_low_o = !b;
        w(q);
        scl_o = 1'b1;
        w(q);
        r = sda_i;
        w(q);
        scl_o = 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic rx(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, r);
    endtask
endmodule
`default_nettype wire

//--- rtc_cfg_pkg.sv
// constants and types shared by the rtc user ram and power configuration slice
package rtc_cfg_pkg;

    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [7:0] user_ram_first     = 8'h16;
    localparam logic [7:0] user_ram_last      = 8'h55;
    localparam logic [7:0] power_config_addr  = 8'h56;
    localparam logic [7:0] charger_config_addr = 8'h57;
    localparam int         user_ram_depth     = 64;
    localparam int         user_ram_aw        = 6;

    // -------------------------------------------------------------------
    // field layout and reset values
    // -------------------------------------------------------------------
    localparam int         analog_mode_lsb    = 0;
    localparam int         override_bit       = 2;
    localparam int         backup_choice_bit  = 3;
    localparam logic [1:0] analog_mode_comparator = 2'h0;
    localparam logic [1:0] analog_mode_power      = 2'h1;
    localparam logic [3:0] power_config_reset   = 4'h0;
    localparam logic [3:0] charger_config_reset = 4'h0;

    // -------------------------------------------------------------------
    // charger path codes
    // -------------------------------------------------------------------
    localparam logic [3:0] charge_3k          = 4'h8;
    localparam logic [3:0] charge_6k          = 4'ha;
    localparam logic [3:0] charge_11k         = 4'hb;
    localparam logic [3:0] charge_3k_diode    = 4'hc;
    localparam logic [3:0] charge_6k_diode    = 4'he;
    localparam logic [3:0] charge_11k_diode   = 4'hf;
    localparam logic [1:0] res_3k             = 2'h1;
    localparam logic [1:0] res_6k             = 2'h2;
    localparam logic [1:0] res_11k            = 2'h3;

    // -------------------------------------------------------------------
    // serial bus
    // -------------------------------------------------------------------
    localparam logic [3:0] bits_per_byte      = 4'h8;

    typedef enum logic [3:0] {
        st_idle    = 4'b0000,
        st_addr    = 4'b0001,
        st_addr_ack = 4'b0010,
        st_ptr     = 4'b0011,
        st_ptr_ack = 4'b0100,
        st_wr      = 4'b0101,
        st_wr_ack  = 4'b0110,
        st_rd      = 4'b0111,
        st_rd_ack  = 4'b1000
    } bus_state_t;

    typedef struct packed {
        logic       connect;
        logic [1:0] resistance;
        logic       extra_diode;
    } charge_path_t;

    typedef struct packed {
        logic [1:0] analog_mode;
        logic       use_backup;
        logic       manual;
    } supply_ctrl_t;

endpackage

//--- rtc_power_regs.sv
// two-wire serial slave with user ram, power and charger configuration
//
// Functional notes
// - sixty-four read/write user bytes live at 0x16 to 0x55 and power up undefined.
// - power register bits 1:0 pick comparator (0) or power management (1), reset 0.
// - with the override bit 2 clear (reset) the supply is chosen automatically.
// - with override set, bit 3 picks main (0) or backup (1) supply.
// - charger register bits 3:0 hold a read/write path selector reset to zero.
// - selector codes 0-7, 9 and d leave the charge path open, others pick a path.
`timescale 1ns/1ps
`default_nettype none

module rtc_power_regs #(
    parameter logic [6:0] dev_addr = 7'h2a  // arbitrary default
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       scl_i,
    input  wire logic                       sda_i,
    output logic                            sda_o,
    output logic                            sda_oe_o,
    input  wire logic                       auto_backup_i,
    output rtc_cfg_pkg::supply_ctrl_t       supply_o,
    output rtc_cfg_pkg::charge_path_t       charge_o
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic                     scl_meta;
        logic                     scl_sync;
        logic                     scl_prev;
        logic                     sda_meta;
        logic                     sda_sync;
        logic                     sda_prev;
        logic                     auto_meta;
        logic                     auto_sync;
        rtc_cfg_pkg::bus_state_t  state;
        logic [3:0]               bit_cnt;
        logic [7:0]               shift;
        logic                     rw;
        logic                     nack;
        logic [7:0]               ptr;
        logic                     drive_low;
        logic [3:0]               power_cfg;
        logic [3:0]               charger_cfg;
        rtc_cfg_pkg::supply_ctrl_t supply;
        rtc_cfg_pkg::charge_path_t charge;
    } regs_t;

    regs_t state_reg;
    regs_t state_next;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       ram_hit;
    logic       ram_we;
    logic [5:0] ram_addr;
    logic [7:0] ram_rdata;
    logic [7:0] rd_byte;

    // -------------------------------------------------------------------
    // bus events, taken only from the second sync stage onward
    // -------------------------------------------------------------------
    assign scl_rise   = state_reg.scl_sync & ~state_reg.scl_prev;
    assign scl_fall   = ~state_reg.scl_sync & state_reg.scl_prev;
    assign start_seen = state_reg.scl_sync & state_reg.scl_prev
                        & state_reg.sda_prev & ~state_reg.sda_sync;
    assign stop_seen  = state_reg.scl_sync & state_reg.scl_prev
                        & ~state_reg.sda_prev & state_reg.sda_sync;

    assign ram_hit  = (state_reg.ptr >= rtc_cfg_pkg::user_ram_first)
                      && (state_reg.ptr <= rtc_cfg_pkg::user_ram_last);
    assign ram_addr = 6'(state_reg.ptr - rtc_cfg_pkg::user_ram_first);
    assign ram_we   = scl_fall && (state_reg.state == rtc_cfg_pkg::st_wr)
                      && (state_reg.bit_cnt == rtc_cfg_pkg::bits_per_byte)
                      && ram_hit;

    rtc_user_ram u_ram (
        .core_clk_i (core_clk_i),
        .wr_en_i    (ram_we),
        .addr_i     (ram_addr),
        .wr_data_i  (state_reg.shift),
        .rd_data_o  (ram_rdata)
    );

    // -------------------------------------------------------------------
    // read mux
    // -------------------------------------------------------------------
    always_comb begin
        if (ram_hit) begin
            rd_byte = ram_rdata;
        end else if (state_reg.ptr == rtc_cfg_pkg::power_config_addr) begin
            rd_byte = {4'h0, state_reg.power_cfg};
        end else if (state_reg.ptr == rtc_cfg_pkg::charger_config_addr) begin
            rd_byte = {4'h0, state_reg.charger_cfg};
        end else begin
            rd_byte = 8'h00;
        end
    end

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        state_next           = state_reg;
        state_next.scl_meta  = scl_i;
        state_next.scl_sync  = state_reg.scl_meta;
        state_next.scl_prev  = state_reg.scl_sync;
        state_next.sda_meta  = sda_i;
        state_next.sda_sync  = state_reg.sda_meta;
        state_next.sda_prev  = state_reg.sda_sync;
        state_next.auto_meta = auto_backup_i;
        state_next.auto_sync = state_reg.auto_meta;

        if (scl_rise && (state_reg.state != rtc_cfg_pkg::st_idle)) begin
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
            if (state_reg.state == rtc_cfg_pkg::st_rd_ack) begin
                state_next.nack = state_reg.sda_sync;
            end else if (state_reg.state != rtc_cfg_pkg::st_rd) begin
                state_next.shift = {state_reg.shift[6:0], state_reg.sda_sync};
            end
        end

        if (scl_fall) begin
            case (state_reg.state)
                rtc_cfg_pkg::st_addr: begin
                    if (state_reg.bit_cnt == rtc_cfg_pkg::bits_per_byte) begin
                        if (state_reg.shift[7:1] == dev_addr) begin
                            state_next.state     = rtc_cfg_pkg::st_addr_ack;
                            state_next.rw        = state_reg.shift[0];
                            state_next.drive_low = 1'b1;
                        end else begin
                            state_next.state = rtc_cfg_pkg::st_idle;
                        end
                    end
                end
                rtc_cfg_pkg::st_addr_ack,
                rtc_cfg_pkg::st_rd_ack: begin
                    state_next.bit_cnt = 4'h0;
                    if (state_reg.state == rtc_cfg_pkg::st_rd_ack && state_reg.nack) begin
                        state_next.drive_low = 1'b0;
                        state_next.state     = rtc_cfg_pkg::st_idle;
                    end else if (state_reg.rw) begin
                        // byte is fetched here, pointer moves on for the next one
                        state_next.shift     = rd_byte;
                        state_next.drive_low = ~rd_byte[7];
                        state_next.ptr       = state_reg.ptr + 8'h01;
                        state_next.state     = rtc_cfg_pkg::st_rd;
                    end else begin
                        state_next.drive_low = 1'b0;
                        state_next.state     = rtc_cfg_pkg::st_ptr;
                    end
                end
                rtc_cfg_pkg::st_ptr: begin
                    if (state_reg.bit_cnt == rtc_cfg_pkg::bits_per_byte) begin
                        state_next.ptr       = state_reg.shift;
                        state_next.drive_low = 1'b1;
                        state_next.state     = rtc_cfg_pkg::st_ptr_ack;
                    end
                end
                rtc_cfg_pkg::st_ptr_ack,
                rtc_cfg_pkg::st_wr_ack: begin
                    state_next.bit_cnt   = 4'h0;
                    state_next.drive_low = 1'b0;
                    state_next.state     = rtc_cfg_pkg::st_wr;
                end
                rtc_cfg_pkg::st_wr: begin
                    if (state_reg.bit_cnt == rtc_cfg_pkg::bits_per_byte) begin
                        if (state_reg.ptr == rtc_cfg_pkg::power_config_addr) begin
                            state_next.power_cfg = state_reg.shift[3:0];
                        end
                        if (state_reg.ptr == rtc_cfg_pkg::charger_config_addr) begin
                            state_next.charger_cfg = state_reg.shift[3:0];
                        end
                        state_next.ptr       = state_reg.ptr + 8'h01;
                        state_next.drive_low = 1'b1;
                        state_next.state     = rtc_cfg_pkg::st_wr_ack;
                    end
                end
                rtc_cfg_pkg::st_rd: begin
                    if (state_reg.bit_cnt == rtc_cfg_pkg::bits_per_byte) begin
                        state_next.drive_low = 1'b0;
                        state_next.state     = rtc_cfg_pkg::st_rd_ack;
                    end else begin
                        state_next.shift     = {state_reg.shift[6:0], 1'b0};
                        state_next.drive_low = ~state_reg.shift[6];
                    end
                end
                default: begin
                    state_next.state = rtc_cfg_pkg::st_idle;
                end
            endcase
        end

        // start and stop override any byte in flight; pointer survives a restart
        if (start_seen) begin
            state_next.state     = rtc_cfg_pkg::st_addr;
            state_next.bit_cnt   = 4'h0;
            state_next.drive_low = 1'b0;
        end else if (stop_seen) begin
            state_next.state     = rtc_cfg_pkg::st_idle;
            state_next.drive_low = 1'b0;
        end

        // -------------------------------------------------------------------
        // supply and charger outputs
        // -------------------------------------------------------------------
        state_next.supply.analog_mode =
            state_reg.power_cfg[rtc_cfg_pkg::analog_mode_lsb +: 2];
        state_next.supply.manual = state_reg.power_cfg[rtc_cfg_pkg::override_bit];
        if (state_reg.power_cfg[rtc_cfg_pkg::override_bit]) begin
            state_next.supply.use_backup =
                state_reg.power_cfg[rtc_cfg_pkg::backup_choice_bit];
        end else begin
            state_next.supply.use_backup = state_reg.auto_sync;
        end

        state_next.charge = '0;
        case (state_reg.charger_cfg)
            rtc_cfg_pkg::charge_3k,
            rtc_cfg_pkg::charge_3k_diode:  state_next.charge.resistance = rtc_cfg_pkg::res_3k;
            rtc_cfg_pkg::charge_6k,
            rtc_cfg_pkg::charge_6k_diode:  state_next.charge.resistance = rtc_cfg_pkg::res_6k;
            rtc_cfg_pkg::charge_11k,
            rtc_cfg_pkg::charge_11k_diode: state_next.charge.resistance = rtc_cfg_pkg::res_11k;
            default:                       state_next.charge.resistance = 2'h0;
        endcase
        state_next.charge.connect     = (state_next.charge.resistance != 2'h0);
        state_next.charge.extra_diode = state_next.charge.connect
                                        & state_reg.charger_cfg[2];
    end

    // -------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg             <= '0;
            state_reg.scl_meta    <= 1'b1;
            state_reg.scl_sync    <= 1'b1;
            state_reg.scl_prev    <= 1'b1;
            state_reg.sda_meta    <= 1'b1;
            state_reg.sda_sync    <= 1'b1;
            state_reg.sda_prev    <= 1'b1;
            state_reg.state       <= rtc_cfg_pkg::st_idle;
            state_reg.power_cfg   <= rtc_cfg_pkg::power_config_reset;
            state_reg.charger_cfg <= rtc_cfg_pkg::charger_config_reset;
        end else begin
            state_reg <= state_next;
        end
    end

    // open drain: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = state_reg.drive_low;
    assign supply_o = state_reg.supply;
    assign charge_o = state_reg.charge;

endmodule

`default_nettype wire

//--- rtc_power_regs_monitor.sv
// assertion checker for the rtc user ram and power configuration slice
`timescale 1ns/1ps
`default_nettype none
module rtc_power_regs_monitor (
    input wire logic                      core_clk_i,
    input wire logic                      rst_i,
    input wire logic                      scl_i,
    input wire logic                      sda_i,
    input wire logic                      sda_o,
    input wire logic                      sda_oe_o,
    input wire logic                      auto_backup_i,
    input wire rtc_cfg_pkg::supply_ctrl_t supply_o,
    input wire rtc_cfg_pkg::charge_path_t charge_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_scl_held;
        scl_i [*2];
    endsequence
    // six cycles covers the input synchroniser plus the output register
    sequence s_auto_quiet;
        (!supply_o.manual && $stable(auto_backup_i)) [*6];
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_sda_open_drain: assert property (sda_o == 1'b0)
        else $error("sda output not low");
    a_reset_clears_cfg: assert property ($fell(rst_i) |->
        supply_o.analog_mode == 2'h0 && !supply_o.manual && charge_o == 4'h0)
        else $error("config not clear after reset");
    a_auto_follows_input: assert property (s_auto_quiet |->
        supply_o.use_backup == auto_backup_i)
        else $error("automatic supply choice not followed");
    a_manual_by_bus: assert property (($changed(supply_o.analog_mode)
        || $changed(supply_o.manual)
        || (supply_o.manual && $changed(supply_o.use_backup))) |-> !$past(scl_i, 2))
        else $error("supply control changed outside a bus write");
    a_charge_by_bus: assert property ($changed(charge_o) |-> !$past(scl_i, 2))
        else $error("charge path changed outside a bus write");
    a_charge_decode: assert property (charge_o.connect == (charge_o.resistance != 2'h0)
        && (!charge_o.extra_diode || charge_o.connect)) else $error("charge path inconsistent");
    a_ack_on_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("sda pulled while scl high");
    a_sda_steady_high: assert property (s_scl_held |-> $stable(sda_oe_o))
        else $error("sda drive changed during scl high");
endmodule
bind rtc_power_regs rtc_power_regs_monitor mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .auto_backup_i(auto_backup_i), .supply_o(supply_o), .charge_o(charge_o));
`default_nettype wire

//--- rtc_user_ram.sv
// 64-byte general purpose user storage, no reset on contents
`timescale 1ns/1ps
`default_nettype none

module rtc_user_ram (
    input  wire logic                           core_clk_i,
    input  wire logic                           wr_en_i,
    input  wire logic [rtc_cfg_pkg::user_ram_aw-1:0] addr_i,
    input  wire logic [7:0]                     wr_data_i,
    output logic      [7:0]                     rd_data_o
);

    // -------------------------------------------------------------------
    // storage
    // -------------------------------------------------------------------
    // contents are random after power-on, so no reset term here
    logic [7:0] mem [rtc_cfg_pkg::user_ram_depth];

    always_ff @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= wr_data_i;
        end
    end

    assign rd_data_o = mem[addr_i];

endmodule

`default_nettype wire

//--- tb_top.sv
// self-checking testbench for the rtc power configuration slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [6:0] dev_id = 7'h15; // arbitrary bus address
    logic                      clk;
    logic                      rst;
    logic                      auto_backup;
    logic                      scl;
    logic                      host_sda_low;
    logic                      sda_oe;
    wire logic                 sda_line;
    rtc_cfg_pkg::supply_ctrl_t supply;
    rtc_cfg_pkg::charge_path_t charge;
    logic [7:0]                bytes [64];
    logic [7:0]                exp_ram [64];
    logic [31:0]               r;
    logic [3:0]                c;
    logic                      ack;
    int                        miscompares;
    int                        samples_checked;
    int                        seed;
    // pulled-up wire, low if either side pulls
    assign sda_line = !(host_sda_low || sda_oe);
    always #5 clk = ~clk;
    rtc_power_regs #(.dev_addr(dev_id)) dut (.core_clk_i(clk), .rst_i(rst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .auto_backup_i(auto_backup),
        .supply_o(supply), .charge_o(charge));
    bus_host_model host (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_sda_low));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] p, input int n);
        host.start();
        host.tx({dev_id, 1'b0}, ack);
        host.tx(p, ack);
        for (int i = 0; i < n; i++) host.tx(bytes[i], ack);
        chk({7'h0, ack}, 8'h00);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        host.start();
        host.tx({dev_id, 1'b0}, ack);
        host.tx(p, ack);
        host.start();
        host.tx({dev_id, 1'b1}, ack);
        for (int i = 0; i < n; i++) host.rx(i == n - 1, bytes[i]);
        host.stop();
    endtask
    function automatic logic [3:0] exp_charge(input logic [3:0] v);
        logic [1:0] res;
        res = 2'h0;
        if (v[3]) begin
            case (v[1:0])
                2'h0: res = 2'h1;
                2'h2: res = 2'h2;
                2'h3: res = 2'h3;
                default: res = 2'h0;
            endcase
        end
        return {res != 2'h0, res, v[2] && res != 2'h0};
    endfunction
    // ----------------------------------------
    // sequence of tests
    // ----------------------------------------
    initial begin
        seed = 32'h332f5e78;
        miscompares = 0;
        samples_checked = 0;
        clk = 1'b0;
        rst = 1'b1;
        auto_backup = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h56, 2);
        chk(bytes[0], 8'h00);
        chk(bytes[1], 8'h00);
        chk({4'h0, supply}, 8'h00);
        chk({4'h0, charge}, 8'h00);
        host.start();
        host.tx({dev_id ^ 7'h01, 1'b0}, ack);
        host.stop();
        chk({7'h0, ack}, 8'h01);
        for (int i = 0; i < 64; i++) bytes[i] = 8'($random(seed));
        bytes[0] = 8'h00;
        bytes[63] = 8'hff;
        exp_ram = bytes;
        wr(rtc_cfg_pkg::user_ram_first, 64);
        host.q = 9; // slow host for the readback
        rd(rtc_cfg_pkg::user_ram_first, 64);
        host.q = 5;
        for (int i = 0; i < 64; i++) chk(bytes[i], exp_ram[i]);
        for (int v = 0; v < 16; v++) begin
            r = $random(seed);
            c = 4'(v);
            bytes[0] = {r[7:4], c};
            bytes[1] = {r[3:0], ~c};
            auto_backup = r[8];
            wr(rtc_cfg_pkg::power_config_addr, 2);
            // redraw the automatic decision from r[9]; manual mode must ignore it
            auto_backup = r[9];
            rd(rtc_cfg_pkg::power_config_addr, 2);
            chk(bytes[0], {4'h0, c});
            chk(bytes[1], {4'h0, ~c});
            chk({4'h0, supply}, {4'h0, c[1:0], c[2] ? c[3] : auto_backup, c[2]});
            chk({4'h0, charge}, {4'h0, exp_charge(~c)});
        end
        bytes[0] = 8'ha5;
        wr(8'h58, 1);
        rd(8'h58, 1);
        chk(bytes[0], 8'h00);
        rd(8'h15, 1);
        chk(bytes[0], 8'h00);
        tally_and_finish();
    end
    // bound well above the expected run of about 65k cycles
    initial begin
        #1_000_000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
